/* File: logic/tcc_top.sv */
// 16-bit timer/event counter with two capture/compare registers, Wishbone slave
// Notes on behaviour
// - counter is 16 bits, read-only, counts up one per count clock.
// - reading the running counter pauses counting, returns a stable snapshot.
// - counter reads return zero while the operation mode is stop.
// - counter clears on reset, stop, edge/match clear modes, one-shot triggers.
// - reading the counter never captures into the second register.
// - both capture/compare registers are 16-bit words, reset to zero.
// - first register compares continuously, raises first match interrupt, value kept.
// - second register compares continuously, raises second match interrupt on equality.
// - a register in compare mode ignores capture triggers.
// - first capture triggers on opposite edge of input one or valid edge of input two.
// - second register captures on valid edge of first input pin.
// - captured value stays until the next capture or a bus write; software rewrites before compare use.
// - capture coinciding with stop leaves an undefined captured value.
// - compare value zero gives no match at start; first match at 0 to 1.
// - opposite-edge capture raises no first interrupt; second input edge raises it.
// - second register capture ignores the first trigger select bit.
// - mode 00 stop and clear, 01 free run, 10 edge clear, 11 match clear.
// - overflow flag sets on wrap or written one, clears on zero or stop.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/100ps
module tcc_top import tcc_pkg::*; #(
	parameter int NUM_CH = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [15:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	input wire logic [NUM_CH-1:0] first_timer_input_i,
	input wire logic [NUM_CH-1:0] second_timer_input_i,
	output logic [NUM_CH-1:0] first_match_irq_o,
	output logic [NUM_CH-1:0] second_match_irq_o,
	output logic [NUM_CH-1:0] timer_output_pin_o
);
	logic bus_req;
	logic bus_wr;
	logic bus_rd;
	logic word_wr;
	logic [15:0] ch_rdata [NUM_CH];
	logic [15:0] rdata_any;

	// at most one request every two cycles; ack falls the cycle after it rose
	assign bus_req = cyc_i & stb_i & ~ack_o;
	assign bus_wr = bus_req & we_i;
	assign bus_rd = bus_req & ~we_i;
	assign word_wr = bus_wr & (sel_i[1:0] == TCC_WORD_SEL);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_req;
		end
	end

	// unmapped addresses decode to no channel and read back zero
	always_comb begin
		rdata_any = TCC_ZERO16;
		for (int i = 0; i < NUM_CH; i++) begin
			rdata_any = rdata_any | ch_rdata[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (bus_rd) begin
			dat_o <= {16'h0000, rdata_any};
		end
	end

	for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
		localparam logic [15:0] BASE = (g == 0) ? TCC_CH0_BASE : TCC_CH1_BASE;

		logic [15:0] count_value;
		logic [15:0] first_capture_compare;
		logic [15:0] second_capture_compare;
		logic [1:0] op_mode;
		logic rev_sel;
		logic overflow_flag;
		logic [TCC_CC_W-1:0] capture_compare_control;
		logic [TCC_PRESC_W-1:0] prescaler_edge_select;
		logic [TCC_OUT_W-1:0] output_control;
		logic [2:0] in0_sync;
		logic [2:0] in1_sync;
		logic fresh_start;

		logic hit_count;
		logic hit_first;
		logic hit_second;
		logic hit_mode;
		logic hit_ccctl;
		logic hit_presc;
		logic hit_out;
		logic running;
		logic hold_count;
		logic tick;
		logic rise0;
		logic fall0;
		logic rise1;
		logic fall1;
		logic valid0;
		logic opposite0;
		logic valid1;
		logic one_shot_trigger;
		logic one_shot_fire;
		logic match0;
		logic match1;
		logic edge_clear;
		logic match_clear;
		logic clear_evt;
		logic wrap;
		logic pin_event;
		logic first_cap_mode;
		logic second_cap_mode;
		logic first_trig;
		logic [1:0] es0;
		logic [1:0] es1;

		assign hit_count = adr_i == BASE + TCC_OFF_COUNT;
		assign hit_first = adr_i == BASE + TCC_OFF_FIRST_CC;
		assign hit_second = adr_i == BASE + TCC_OFF_SECOND_CC;
		assign hit_mode = adr_i == BASE + TCC_OFF_MODE;
		assign hit_ccctl = adr_i == BASE + TCC_OFF_CC_CTRL;
		assign hit_presc = adr_i == BASE + TCC_OFF_PRESC;
		assign hit_out = adr_i == BASE + TCC_OFF_OUT_CTRL;

		// pins are asynchronous: two stages before any edge logic looks
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				in0_sync <= 3'h0;
			end else begin
				in0_sync <= {in0_sync[1:0], first_timer_input_i[g]};
			end
		end

		// reset level matches the idle pin level, so no false edge after reset
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				in1_sync <= 3'h0;
			end else begin
				in1_sync <= {in1_sync[1:0], second_timer_input_i[g]};
			end
		end

		assign rise0 = in0_sync[1] & ~in0_sync[2];
		assign fall0 = ~in0_sync[1] & in0_sync[2];
		assign rise1 = in1_sync[1] & ~in1_sync[2];
		assign fall1 = ~in1_sync[1] & in1_sync[2];
		assign es0 = prescaler_edge_select[TCC_PRESC_ES0_LO +: 2];
		assign es1 = prescaler_edge_select[TCC_PRESC_ES1_LO +: 2];

		// both-edge setting leaves no opposite phase to detect
		always_comb begin
			case (es0)
				TCC_ES_RISE: begin
					valid0 = rise0;
					opposite0 = fall0;
				end
				TCC_ES_BOTH: begin
					valid0 = rise0 | fall0;
					opposite0 = 1'b0;
				end
				default: begin
					valid0 = fall0;
					opposite0 = rise0;
				end
			endcase
		end

		// code 10 is not a documented edge choice; treated as falling
		always_comb begin
			case (es1)
				TCC_ES_RISE: begin
					valid1 = rise1;
				end
				TCC_ES_BOTH: begin
					valid1 = rise1 | fall1;
				end
				default: begin
					valid1 = fall1;
				end
			endcase
		end

		assign running = op_mode != TCC_OP_STOP;
		// count clock is held off for the cycle a counter read is taken
		assign hold_count = bus_rd & hit_count;
		assign tick = running & ~hold_count;
		assign first_cap_mode = capture_compare_control[TCC_CC_FIRST_CAPTURE];
		assign second_cap_mode = capture_compare_control[TCC_CC_SECOND_CAPTURE];

		// a match is seen as the counter leaves the compare value
		assign match0 = tick & ~fresh_start & ~first_cap_mode & (count_value == first_capture_compare);
		assign match1 = tick & ~fresh_start & ~second_cap_mode & (count_value == second_capture_compare);

		assign one_shot_trigger = word_wr & hit_out & dat_i[TCC_OUT_ONE_SHOT_TRIG];
		assign one_shot_fire = running & output_control[TCC_OUT_ONE_SHOT_EN] & (one_shot_trigger | valid0);
		assign edge_clear = (op_mode == TCC_OP_EDGE_CLEAR) & valid0;
		assign match_clear = (op_mode == TCC_OP_MATCH_CLEAR) & match0;
		assign clear_evt = edge_clear | match_clear | one_shot_fire;
		assign wrap = tick & ~clear_evt & (count_value == TCC_MAX16);

		// suppresses a zero-valued compare hit on the very first step after start
		always_ff @(posedge clk_i) begin
			if (rst_i || !running) begin
				fresh_start <= 1'b1;
			end else if (tick) begin
				fresh_start <= 1'b0;
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i || !running) begin
				count_value <= TCC_ZERO16;
			end else if (clear_evt) begin
				count_value <= TCC_ZERO16;
			end else if (tick) begin
				count_value <= count_value + TCC_ONE16;
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				op_mode <= TCC_OP_STOP;
			end else if (word_wr && hit_mode) begin
				op_mode <= dat_i[TCC_MODE_OP_HI:TCC_MODE_OP_LO];
			end
		end

		// rewrites while running are accepted; software keeps to the stop rule
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				rev_sel <= 1'b0;
			end else if (word_wr && hit_mode) begin
				rev_sel <= dat_i[TCC_MODE_REV_SEL];
			end
		end

		// a wrap in the same cycle as a write of zero still sets the flag
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				overflow_flag <= 1'b0;
			end else if (word_wr && hit_mode) begin
				overflow_flag <= dat_i[TCC_MODE_OVF] | wrap;
			end else if (wrap) begin
				overflow_flag <= 1'b1;
			end else if (!running) begin
				overflow_flag <= 1'b0;
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				capture_compare_control <= '0;
			end else if (word_wr && hit_ccctl) begin
				capture_compare_control <= dat_i[TCC_CC_W-1:0];
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				prescaler_edge_select <= '0;
			end else if (word_wr && hit_presc) begin
				prescaler_edge_select <= dat_i[TCC_PRESC_W-1:0];
			end
		end

		// the software trigger bit is not stored, so it always reads zero
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				output_control <= '0;
			end else if (word_wr && hit_out) begin
				output_control <= dat_i[TCC_OUT_W-1:0];
			end
		end

		assign first_trig = capture_compare_control[TCC_CC_FIRST_TRIG_SEL] ? opposite0 : valid1;

		// capture only while running; a stop racing a trigger gives no promised value
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				first_capture_compare <= TCC_ZERO16;
			end else if (first_cap_mode && running && first_trig) begin
				first_capture_compare <= count_value;
			end else if (word_wr && hit_first) begin
				first_capture_compare <= dat_i[15:0];
			end
		end

		// bus counter reads do not appear among the triggers here
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				second_capture_compare <= TCC_ZERO16;
			end else if (second_cap_mode && running && valid0) begin
				second_capture_compare <= count_value;
			end else if (word_wr && hit_second) begin
				second_capture_compare <= dat_i[15:0];
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				first_match_irq_o[g] <= 1'b0;
			end else begin
				// in capture mode the first interrupt follows the second input only
				first_match_irq_o[g] <= first_cap_mode ? (running & valid1) : match0;
			end
		end

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				second_match_irq_o[g] <= 1'b0;
			end else begin
				second_match_irq_o[g] <= second_cap_mode ? (running & valid0) : match1;
			end
		end

		// both matches in one cycle toggle the pin once, not twice
		assign pin_event = rev_sel ? valid0 : (match0 | match1);

		always_ff @(posedge clk_i) begin
			if (rst_i || !running) begin
				timer_output_pin_o[g] <= 1'b0;
			end else if (output_control[TCC_OUT_ENABLE]) begin
				if (pin_event) begin
					timer_output_pin_o[g] <= ~timer_output_pin_o[g];
				end
			end
		end

		// other channels return zero here, so the bus side can simply or them
		always_comb begin
			ch_rdata[g] = TCC_ZERO16;
			case (1'b1)
				hit_count: begin
					ch_rdata[g] = running ? count_value : TCC_ZERO16;
				end
				hit_first: begin
					ch_rdata[g] = first_capture_compare;
				end
				hit_second: begin
					ch_rdata[g] = second_capture_compare;
				end
				hit_mode: begin
					ch_rdata[g] = {12'h000, op_mode, rev_sel, overflow_flag};
				end
				hit_ccctl: begin
					ch_rdata[g] = {13'h0000, capture_compare_control};
				end
				hit_presc: begin
					ch_rdata[g] = {8'h00, prescaler_edge_select};
				end
				hit_out: begin
					ch_rdata[g] = {14'h0000, output_control};
				end
				default: begin
					ch_rdata[g] = TCC_ZERO16;
				end
			endcase
		end
	end
endmodule

/* File: logic/tcc_pkg.sv */
// constants shared by the 16-bit capture/compare timer
package tcc_pkg;
	// register byte addresses; channel base plus a register offset
	localparam logic [15:0] TCC_CH0_BASE = 16'hff10;
	localparam logic [15:0] TCC_CH1_BASE = 16'hffb0;
	localparam logic [15:0] TCC_OFF_COUNT = 16'h0000;
	localparam logic [15:0] TCC_OFF_FIRST_CC = 16'h0004;
	localparam logic [15:0] TCC_OFF_SECOND_CC = 16'h0008;
	localparam logic [15:0] TCC_OFF_MODE = 16'h000c;
	localparam logic [15:0] TCC_OFF_CC_CTRL = 16'h0010;
	localparam logic [15:0] TCC_OFF_PRESC = 16'h0014;
	localparam logic [15:0] TCC_OFF_OUT_CTRL = 16'h0018;

	// mode_control fields
	localparam int TCC_MODE_OVF = 0;
	localparam int TCC_MODE_REV_SEL = 1;
	localparam int TCC_MODE_OP_LO = 2;
	localparam int TCC_MODE_OP_HI = 3;

	// operation modes held in op_mode_bit_hi/op_mode_bit_lo
	localparam logic [1:0] TCC_OP_STOP = 2'h0;
	localparam logic [1:0] TCC_OP_FREE = 2'h1;
	localparam logic [1:0] TCC_OP_EDGE_CLEAR = 2'h2;
	localparam logic [1:0] TCC_OP_MATCH_CLEAR = 2'h3;

	// capture_compare_control fields
	localparam int TCC_CC_FIRST_CAPTURE = 0;
	localparam int TCC_CC_FIRST_TRIG_SEL = 1;
	localparam int TCC_CC_SECOND_CAPTURE = 2;
	localparam int TCC_CC_W = 3;

	// prescaler_edge_select fields: edge codes of each input
	localparam int TCC_PRESC_ES0_LO = 4;
	localparam int TCC_PRESC_ES1_LO = 6;
	localparam int TCC_PRESC_W = 8;
	localparam logic [1:0] TCC_ES_FALL = 2'h0;
	localparam logic [1:0] TCC_ES_RISE = 2'h1;
	localparam logic [1:0] TCC_ES_BOTH = 2'h3;

	// output_control fields
	localparam int TCC_OUT_ENABLE = 0;
	localparam int TCC_OUT_ONE_SHOT_EN = 1;
	localparam int TCC_OUT_ONE_SHOT_TRIG = 2;
	localparam int TCC_OUT_W = 2;

	localparam logic [15:0] TCC_ZERO16 = 16'h0000;
	localparam logic [15:0] TCC_MAX16 = 16'hffff;
	localparam logic [15:0] TCC_ONE16 = 16'h0001;
	localparam logic [1:0] TCC_WORD_SEL = 2'h3;
endpackage

/* File: verif/tcc_chk_sva.sv */
// assertion checker for the capture/compare timer
`timescale 1ns/100ps
module tcc_chk import tcc_pkg::*; #(
	parameter int NUM_CH = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [15:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [3:0] sel_i,
	input wire logic ack_o,
	input wire logic [31:0] dat_o,
	input wire logic [NUM_CH-1:0] first_timer_input_i,
	input wire logic [NUM_CH-1:0] second_timer_input_i,
	input wire logic [NUM_CH-1:0] first_match_irq_o,
	input wire logic [NUM_CH-1:0] second_match_irq_o,
	input wire logic [NUM_CH-1:0] timer_output_pin_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] op0;
	logic take;
	assign take = cyc_i && stb_i && !ack_o;
	// mirror of the channel 0 operation mode, from accepted word writes
	always_ff @(posedge clk_i) begin
		if (rst_i)
			op0 <= TCC_OP_STOP;
		else if (take && we_i && adr_i == TCC_CH0_BASE + TCC_OFF_MODE && sel_i[1:0] == 2'h3)
			op0 <= dat_i[3:2];
	end
	chk_ack_answer: assert property (take |=> ack_o) else $error("no ack after request");
	chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	chk_ack_cause: assert property (ack_o |-> $past(take)) else $error("ack without request");
	chk_read_upper: assert property (ack_o && !$past(we_i) |-> dat_o[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_stop_count: assert property (take && !we_i && adr_i == TCC_CH0_BASE && op0 == TCC_OP_STOP
		|=> dat_o[15:0] == 16'h0000) else $error("stopped count read not zero");
	chk_stop_quiet: assert property ((op0 == TCC_OP_STOP)[*3]
		|-> !first_match_irq_o[0] && !second_match_irq_o[0]) else $error("interrupt while stopped");
	chk_stop_pin: assert property ((op0 == TCC_OP_STOP)[*2] |-> !timer_output_pin_o[0])
		else $error("output pin high while stopped");
	chk_irq1_pulse: assert property (first_match_irq_o[0] |=> !first_match_irq_o[0])
		else $error("first interrupt too long");
	chk_irq2_pulse: assert property (second_match_irq_o[0] |=> !second_match_irq_o[0])
		else $error("second interrupt too long");
	cover property (take && we_i);
	cover property (first_match_irq_o[0]);
	cover property (second_match_irq_o[0]);
	cover property ($rose(timer_output_pin_o[0]));
endmodule
bind tcc_top tcc_chk #(.NUM_CH(NUM_CH)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .dat_o(dat_o),
	.first_timer_input_i(first_timer_input_i), .second_timer_input_i(second_timer_input_i),
	.first_match_irq_o(first_match_irq_o), .second_match_irq_o(second_match_irq_o),
	.timer_output_pin_o(timer_output_pin_o));

/* File: verif/tcc_pulse_src.sv */
// pulse source model driving the timer input pins
`timescale 1ns/100ps
module tcc_pulse_src #(
	parameter int NUM_CH = 2
) (
	input wire logic clk_i,
	input wire logic [2*NUM_CH-1:0] flip_i,
	output logic [NUM_CH-1:0] first_o,
	output logic [NUM_CH-1:0] second_o
);
	logic [2*NUM_CH-1:0] lvl = '0;
	logic [2*NUM_CH-1:0] pend = '0;
	logic [2:0] gap = '0;
	assign {second_o, first_o} = lvl;
	// a level holds five clocks at least; closer requests wait their turn
	always @(posedge clk_i) begin
		if (gap == 3'h0 && (pend | flip_i) != '0) begin
			lvl <= lvl ^ (pend | flip_i);
			pend <= '0;
			gap <= 3'h4;
		end else begin
			pend <= pend | flip_i;
			gap <= (gap == 3'h0) ? gap : gap - 3'h1;
		end
	end
endmodule

/* File: verif/tcc_top_tb.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tcc_top_tb import tcc_pkg::*;;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [15:0] adr_i;
	logic [31:0] dat_i, dat_o, q;
	logic [3:0] sel_i, flip;
	logic [1:0] fin, sin, fir, sir, tpin;
	logic [31:0] seed = 32'h9d78;
	logic [15:0] v, nn, mm, c;
	int mismatches = 0, n_checks = 0, cyc_n = 0, t, t1, n, i;
	tcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o), .dat_o(dat_o), .first_timer_input_i(fin),
		.second_timer_input_i(sin), .first_match_irq_o(fir), .second_match_irq_o(sir), .timer_output_pin_o(tpin));
	tcc_pulse_src src (.clk_i(clk_i), .flip_i(flip), .first_o(fin), .second_o(sin));
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc_n <= cyc_n + 1;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [1:0] s);
		int k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= {2'h0, s};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		if (k == 50) mismatches++;
		q = dat_o;
		t = cyc_n;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		bus(1'b1, TCC_CH0_BASE + a, d, 2'h3);
	endtask
	task automatic wirq(input logic second);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((second ? sir[0] : fir[0]) !== 1'b1 && n < 200);
	endtask
	task automatic pulse(input logic [3:0] b);
		flip <= b;
		@(posedge clk_i);
		flip <= 4'h0;
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{clk_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i, flip} = '0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		for (i = 0; i < 3; i++) begin
			bus(1'b0, TCC_CH0_BASE + 16'(4 * i), 0, 2'h3); `CHK("reset_value", 16'h0000, q[15:0])
		end
		bus(1'b0, TCC_CH1_BASE, 0, 2'h3); `CHK("ch1_count", 16'h0000, q[15:0])
		bus(1'b0, 16'h0100, 0, 2'h3); `CHK("unmapped", 32'h0, q)
		seed = lfsr(seed);
		v = seed[15:0];
		wr(TCC_OFF_FIRST_CC, {16'h0, v});
		bus(1'b1, TCC_CH0_BASE + TCC_OFF_FIRST_CC, {16'h0, ~v}, 2'h1);
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_FIRST_CC, 0, 2'h3); `CHK("first_cc", v, q[15:0])
		wr(TCC_OFF_MODE, 32'h5);
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_MODE, 0, 2'h3); `CHK("ovf_set", 4'h5, q[3:0])
		bus(1'b0, TCC_CH0_BASE, 0, 2'h3);
		c = q[15:0];
		t1 = t;
		repeat (1 + seed[18:16]) @(posedge clk_i);
		bus(1'b0, TCC_CH0_BASE, 0, 2'h3); `CHK("count_step", 16'(c + t - t1 - 1), q[15:0])
		wr(TCC_OFF_MODE, 32'h4);
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_MODE, 0, 2'h3); `CHK("ovf_clr", 4'h4, q[3:0])
		wr(TCC_OFF_MODE, 32'h0);
		bus(1'b0, TCC_CH0_BASE, 0, 2'h3); `CHK("stop_count", 16'h0000, q[15:0])
		seed = lfsr(seed);
		nn = 16'h5 + 16'(seed[4:0]);
		mm = nn - 16'h1 - 16'(seed[6:5]);
		wr(TCC_OFF_FIRST_CC, {16'h0, nn});
		wr(TCC_OFF_SECOND_CC, {16'h0, mm});
		wr(TCC_OFF_MODE, 32'hc);
		wirq(1'b0);
		wirq(1'b0); `CHK("match_period", nn + 16'h1, 16'(n))
		wirq(1'b1); `CHK("second_match", 1'b1, n <= int'(nn) + 1)
		wr(TCC_OFF_MODE, 32'h0);
		wr(TCC_OFF_CC_CTRL, 32'h4);
		wr(TCC_OFF_PRESC, 32'h50);
		wr(TCC_OFF_MODE, 32'h4);
		repeat (20) @(posedge clk_i);
		pulse(4'h1);
		wirq(1'b1); `CHK("second_capture_irq", 1'b1, n < 20)
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_SECOND_CC, 0, 2'h3);
		c = q[15:0]; `CHK("captured", 1'b1, c != 16'h0)
		bus(1'b0, TCC_CH0_BASE, 0, 2'h3);
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_SECOND_CC, 0, 2'h3); `CHK("read_no_capture", c, q[15:0])
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_FIRST_CC, 0, 2'h3); `CHK("compare_kept", nn, q[15:0])
		wr(TCC_OFF_MODE, 32'h0);
		wr(TCC_OFF_CC_CTRL, 32'h3);
		wr(TCC_OFF_MODE, 32'h4);
		pulse(4'h1);
		wirq(1'b0); `CHK("no_irq_after_capture", 1'b1, n == 200)
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_FIRST_CC, 0, 2'h3);
		c = q[15:0];
		pulse(4'h4);
		wirq(1'b0); `CHK("ext_irq", 1'b1, n < 20)
		bus(1'b0, TCC_CH0_BASE + TCC_OFF_FIRST_CC, 0, 2'h3); `CHK("ext_no_capture", c, q[15:0])
		wr(TCC_OFF_MODE, 32'h0);
		wr(TCC_OFF_CC_CTRL, 32'h0);
		wr(TCC_OFF_FIRST_CC, {16'h0, nn});
		wr(TCC_OFF_SECOND_CC, {16'h0, nn});
		wr(TCC_OFF_OUT_CTRL, 32'h1);
		wr(TCC_OFF_MODE, 32'hc);
		wirq(1'b0); `CHK("pin_toggle", 1'b1, tpin[0])
		wirq(1'b0); `CHK("pin_back", 1'b0, tpin[0])
		report_and_stop;
	end
	initial begin
		#50000;
		mismatches++;
		report_and_stop;
	end
endmodule
